// file: src/cxab_bridge.sv
// Notes on behaviour
// RULE_01 - Data register carries indirect write/read word
// RULE_02 - Direct accesses never touch data register
// RULE_03 - High address 12:0 kept, 15:13 read zero
// RULE_04 - Low address kept; direct uses top bits
// RULE_05 - Indirect reaches full space via four words
// RULE_06 - Host holds select low for indirect
// RULE_07 - Host writes address/data before launching
// RULE_08 - Host launches with one control write
// RULE_09 - Hardware clears request bit when done
// RULE_10 - Read: enables 00, data valid at clear
// RULE_11 - Indirect read parity shown in 15:14
// RULE_12 - Direct: page base plus host offset
// RULE_13 - Direct access only with select high
// RULE_14 - Direct ignores low register lower bits
// RULE_15 - Host sets enables before direct write
// RULE_16 - Direct read parity shown in 15:14
// RULE_17 - Enables: read, low, high, whole word
// RULE_18 - Enables unused for direct read, bytes
// RULE_19 - Read prefetch burst, split at 256 bytes
// RULE_20 - One internal access at a time
`default_nettype none
module cxab_bridge #(
    parameter int DATA_W = 16
) (
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESETN,
    // Host access port
    input  wire logic        HOST_SEL,
    input  wire logic        HOST_WR,
    input  wire logic        HOST_DAS,
    input  wire logic        HOST_BUS8,
    input  wire logic [15:0] HOST_ADDR,
    input  wire logic [15:0] HOST_WDATA,
    output logic      [15:0] HOST_RDATA,
    output logic             HOST_READY,
    // Internal memory port
    output logic             MEM_REQ,
    output logic      [32:0] MEM_ADDR,
    output logic      [1:0]  MEM_WE,
    output logic      [15:0] MEM_WDATA,
    output logic      [1:0]  MEM_WPAR,
    output logic      [7:0]  MEM_BURST,
    input  wire logic        MEM_ACK,
    input  wire logic [15:0] MEM_RDATA,
    input  wire logic [1:0]  MEM_RPAR
);
    generate
        if (DATA_W != 16) begin : g_bad_width
            $error("cxab_bridge serves a 16-bit word only");
        end
    endgenerate

    // Byte merge for 8-bit host writes
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] w,
                                          input logic b8, input logic a0);
        if (!b8) begin
            merge = w;
        end else if (a0) begin
            merge = {w[7:0], old[7:0]};
        end else begin
            merge = {old[15:8], w[7:0]};
        end
    endfunction : merge

    // Byte lane for 8-bit host reads
    function automatic logic [15:0] lane(input logic [15:0] w, input logic b8, input logic a0);
        if (!b8) begin
            lane = w;
        end else begin
            lane = {8'h00, a0 ? w[15:8] : w[7:0]};
        end
    endfunction : lane

    // Register state
    logic [6:0]  burst_len,   next_burst_len;
    logic        req,         next_req;
    logic [2:0]  xa31,        next_xa31;
    logic [1:0]  we,          next_we;
    logic [1:0]  par,         next_par;
    logic [15:0] data,        next_data;
    logic [12:0] ahi,         next_ahi;
    logic [15:0] alo,         next_alo;
    // Sequencer state
    cxab_pkg::cxab_state_t state, next_state;
    logic        cur_ind,     next_cur_ind;
    logic        cur_rd,      next_cur_rd;
    logic        cur_b8,      next_cur_b8;
    logic        cur_a0,      next_cur_a0;
    logic [7:0]  rest,        next_rest;
    // Pending direct access
    logic        dir_pend,    next_dir_pend;
    logic        dir_wr,      next_dir_wr;
    logic        dir_b8,      next_dir_b8;
    logic [32:0] dir_addr,    next_dir_addr;
    logic [1:0]  dir_be,      next_dir_be;
    logic [15:0] dir_wdata,   next_dir_wdata;
    // Outputs
    logic [15:0] next_host_rdata;
    logic        next_host_ready;
    logic        next_mem_req;
    logic [32:0] next_mem_addr;
    logic [1:0]  next_mem_we;
    logic [15:0] next_mem_wdata;
    logic [1:0]  next_mem_wpar;
    logic [7:0]  next_mem_burst;

    logic [15:0] ctrl_word;
    logic [15:0] new_ctrl;
    logic [15:0] reg_addr;
    logic [15:0] ahi_wr;
    logic [32:0] ind_addr;
    logic [7:0]  first_len;
    logic [7:0]  rest_len;

    // Control word view; bit 7 reads zero
    always_comb begin
        ctrl_word = {par, we, xa31, req, 1'b0, burst_len};
        reg_addr  = {HOST_ADDR[15:1], 1'b0};
        new_ctrl  = merge(ctrl_word, HOST_WDATA, HOST_BUS8, HOST_ADDR[0]);
        ahi_wr    = merge({3'h0, ahi}, HOST_WDATA, HOST_BUS8, HOST_ADDR[0]);
        ind_addr  = {ahi, alo, xa31, 1'b0}; // [RULE_05]
    end

    // Burst length for the next read, cut at the span boundary
    cxab_burst_split u_split (
        .word_in_span (state == cxab_pkg::ST_IDLE && !req ? dir_addr[7:1] : ind_addr[7:1]),
        .len_field    (burst_len),
        .first_len    (first_len),
        .rest_len     (rest_len)
    );

    // Next-state logic for registers, sequencer and outputs
    always_comb begin
        next_burst_len  = burst_len;
        next_req        = req;
        next_xa31       = xa31;
        next_we         = we;
        next_par        = par;
        next_data       = data;
        next_ahi        = ahi;
        next_alo        = alo;
        next_state      = state;
        next_cur_ind    = cur_ind;
        next_cur_rd     = cur_rd;
        next_cur_b8     = cur_b8;
        next_cur_a0     = cur_a0;
        next_rest       = rest;
        next_dir_pend   = dir_pend;
        next_dir_wr     = dir_wr;
        next_dir_b8     = dir_b8;
        next_dir_addr   = dir_addr;
        next_dir_be     = dir_be;
        next_dir_wdata  = dir_wdata;
        next_host_rdata = HOST_RDATA;
        next_host_ready = 1'b0;
        next_mem_req    = MEM_REQ;
        next_mem_addr   = MEM_ADDR;
        next_mem_we     = MEM_WE;
        next_mem_wdata  = MEM_WDATA;
        next_mem_wpar   = MEM_WPAR;
        next_mem_burst  = MEM_BURST;

        // Host access, taken only when no direct access is outstanding
        if (HOST_SEL && !dir_pend) begin
            if (HOST_DAS) begin
                // Page base from address registers, offset from host pins [RULE_12] [RULE_13]
                next_dir_pend = 1'b1;
                next_dir_wr   = HOST_WR;
                next_dir_b8   = HOST_BUS8;
                if (HOST_BUS8) begin
                    next_dir_addr  = {ahi, alo[15:11], HOST_ADDR[14:1], 1'b0}; // [RULE_04] [RULE_14]
                    next_dir_be    = HOST_ADDR[0] ? cxab_pkg::WE_HIGH : cxab_pkg::WE_LOW; // [RULE_18]
                    next_dir_wdata = {HOST_WDATA[7:0], HOST_WDATA[7:0]};
                end else begin
                    next_dir_addr  = {ahi, alo[15:12], HOST_ADDR[15:1], 1'b0}; // [RULE_04] [RULE_14]
                    next_dir_be    = we; // [RULE_15] [RULE_17]
                    next_dir_wdata = HOST_WDATA; // [RULE_02]
                end
                if (!HOST_WR) begin
                    next_dir_be = cxab_pkg::WE_READ; // [RULE_18]
                end
                next_cur_a0 = HOST_ADDR[0];
            end else begin
                next_host_ready = 1'b1;
                if (HOST_WR) begin
                    if (reg_addr == cxab_pkg::OFS_CTRL && !req) begin
                        // Control is frozen while an access is pending [RULE_20]
                        next_burst_len = new_ctrl[cxab_pkg::CTRL_BURST_LSB +: cxab_pkg::BURST_W];
                        next_req       = new_ctrl[cxab_pkg::CTRL_REQ_BIT]; // [RULE_08]
                        next_xa31      = new_ctrl[cxab_pkg::CTRL_XA_LSB +: 3];
                        next_we        = new_ctrl[cxab_pkg::CTRL_WE_LSB +: 2];
                        next_par       = new_ctrl[cxab_pkg::CTRL_PAR_LSB +: 2];
                    end else if (reg_addr == cxab_pkg::OFS_DATA) begin
                        next_data = merge(data, HOST_WDATA, HOST_BUS8, HOST_ADDR[0]); // [RULE_01]
                    end else if (reg_addr == cxab_pkg::OFS_AHI) begin
                        next_ahi = ahi_wr[12:0]; // [RULE_03]
                    end else if (reg_addr == cxab_pkg::OFS_ALO) begin
                        next_alo = merge(alo, HOST_WDATA, HOST_BUS8, HOST_ADDR[0]); // [RULE_04]
                    end
                end else begin
                    case (reg_addr)
                        cxab_pkg::OFS_CTRL: next_host_rdata = lane(ctrl_word, HOST_BUS8, HOST_ADDR[0]);
                        cxab_pkg::OFS_DATA: next_host_rdata = lane(data, HOST_BUS8, HOST_ADDR[0]);
                        cxab_pkg::OFS_AHI:  next_host_rdata = lane({3'h0, ahi}, HOST_BUS8, HOST_ADDR[0]); // [RULE_03]
                        cxab_pkg::OFS_ALO:  next_host_rdata = lane(alo, HOST_BUS8, HOST_ADDR[0]);
                        default:            next_host_rdata = 16'h0000;
                    endcase
                end
            end
        end

        // Internal access sequencer, one access at a time
        case (state)
            cxab_pkg::ST_IDLE: begin
                if (req) begin
                    // Indirect access from the four control words [RULE_05] [RULE_20]
                    next_state     = cxab_pkg::ST_FIRST;
                    next_cur_ind   = 1'b1;
                    next_cur_rd    = (we == cxab_pkg::WE_READ); // [RULE_10] [RULE_17]
                    next_mem_req   = 1'b1;
                    next_mem_addr  = ind_addr;
                    next_mem_we    = we;
                    next_mem_wdata = data; // [RULE_01]
                    next_mem_wpar  = par;
                    next_mem_burst = (we == cxab_pkg::WE_READ) ? first_len : 8'h01; // [RULE_19]
                    next_rest      = (we == cxab_pkg::WE_READ) ? rest_len : 8'h00;
                end else if (dir_pend) begin
                    next_state     = cxab_pkg::ST_FIRST;
                    next_cur_ind   = 1'b0;
                    next_cur_rd    = !dir_wr;
                    next_cur_b8    = dir_b8;
                    next_mem_req   = 1'b1;
                    next_mem_addr  = dir_addr;
                    next_mem_we    = dir_be;
                    next_mem_wdata = dir_wdata; // [RULE_02]
                    next_mem_wpar  = par;
                    next_mem_burst = dir_wr ? 8'h01 : first_len; // [RULE_19]
                    next_rest      = dir_wr ? 8'h00 : rest_len;
                end
            end
            cxab_pkg::ST_FIRST: begin
                if (MEM_ACK) begin
                    next_mem_req = 1'b0;
                    if (cur_rd) begin
                        next_par = MEM_RPAR; // [RULE_11] [RULE_16]
                        if (cur_ind) begin
                            next_data = MEM_RDATA; // [RULE_01]
                        end
                    end
                    if (!cur_ind) begin
                        next_dir_pend   = 1'b0;
                        next_host_ready = 1'b1;
                        if (cur_rd) begin
                            next_host_rdata = lane(MEM_RDATA, cur_b8, cur_a0); // [RULE_02]
                        end
                    end
                    if (rest != 8'h00) begin
                        // Remainder of a split burst starts at the next span [RULE_19]
                        next_state     = cxab_pkg::ST_SECOND;
                        next_mem_req   = 1'b1;
                        next_mem_addr  = {MEM_ADDR[32:8] + 25'h0000001, 8'h00};
                        next_mem_burst = rest;
                        next_rest      = 8'h00;
                    end else begin
                        next_state = cxab_pkg::ST_IDLE;
                        if (cur_ind) begin
                            next_req = 1'b0; // [RULE_09] [RULE_10]
                        end
                    end
                end
            end
            cxab_pkg::ST_SECOND: begin
                if (MEM_ACK) begin
                    next_mem_req = 1'b0;
                    next_state   = cxab_pkg::ST_IDLE;
                    if (cur_ind) begin
                        next_req = 1'b0; // [RULE_09]
                    end
                end
            end
            default: begin
                next_state   = cxab_pkg::ST_IDLE;
                next_mem_req = 1'b0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            burst_len  <= cxab_pkg::BURST_RESET;
            we         <= cxab_pkg::WE_READ;
            data       <= cxab_pkg::DATA_RESET;
            ahi        <= cxab_pkg::AHI_RESET;
            alo        <= cxab_pkg::ALO_RESET;
            state      <= cxab_pkg::ST_IDLE;
            {req, xa31, par, cur_ind, cur_rd, cur_b8, cur_a0, rest} <= '0;
            {dir_pend, dir_wr, dir_b8, dir_addr, dir_be, dir_wdata} <= '0;
            {HOST_RDATA, HOST_READY, MEM_REQ, MEM_ADDR, MEM_WE, MEM_WDATA, MEM_WPAR, MEM_BURST} <= '0;
        end else begin
            burst_len  <= next_burst_len;
            req        <= next_req;
            xa31       <= next_xa31;
            we         <= next_we;
            par        <= next_par;
            data       <= next_data;
            ahi        <= next_ahi;
            alo        <= next_alo;
            state      <= next_state;
            cur_ind    <= next_cur_ind;
            cur_rd     <= next_cur_rd;
            cur_b8     <= next_cur_b8;
            cur_a0     <= next_cur_a0;
            rest       <= next_rest;
            dir_pend   <= next_dir_pend;
            dir_wr     <= next_dir_wr;
            dir_b8     <= next_dir_b8;
            dir_addr   <= next_dir_addr;
            dir_be     <= next_dir_be;
            dir_wdata  <= next_dir_wdata;
            HOST_RDATA <= next_host_rdata;
            HOST_READY <= next_host_ready;
            MEM_REQ    <= next_mem_req;
            MEM_ADDR   <= next_mem_addr;
            MEM_WE     <= next_mem_we;
            MEM_WDATA  <= next_mem_wdata;
            MEM_WPAR   <= next_mem_wpar;
            MEM_BURST  <= next_mem_burst;
        end
    end
endmodule : cxab_bridge
`default_nettype wire

// file: src/cxab_pkg.sv
`default_nettype none
package cxab_pkg;
    // Register byte offsets
    localparam logic [15:0] OFS_CTRL      = 16'h0000;
    localparam logic [15:0] OFS_DATA      = 16'h0004;
    localparam logic [15:0] OFS_AHI       = 16'h0008;
    localparam logic [15:0] OFS_ALO       = 16'h000a;
    // Control register field positions
    localparam int          CTRL_BURST_LSB = 0;
    localparam int          CTRL_RSVD_BIT  = 7;
    localparam int          CTRL_REQ_BIT   = 8;
    localparam int          CTRL_XA_LSB    = 9;
    localparam int          CTRL_WE_LSB    = 12;
    localparam int          CTRL_PAR_LSB   = 14;
    // Widths
    localparam int          BURST_W        = 7;
    localparam int          AHI_W          = 13;
    localparam int          ADDR_W         = 33;
    // Values after reset
    localparam logic [6:0]  BURST_RESET    = 7'h01;
    localparam logic [15:0] DATA_RESET     = 16'h0000;
    localparam logic [12:0] AHI_RESET      = 13'h0000;
    localparam logic [15:0] ALO_RESET      = 16'h0000;
    // Byte-enable encodings
    localparam logic [1:0]  WE_READ        = 2'h0;
    localparam logic [1:0]  WE_LOW         = 2'h1;
    localparam logic [1:0]  WE_HIGH        = 2'h2;
    localparam logic [1:0]  WE_WORD        = 2'h3;
    // Burst sizing: words in a 256-byte span
    localparam logic [7:0]  SPAN_WORDS     = 8'h80;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FIRST,
        ST_SECOND
    } cxab_state_t;
endpackage : cxab_pkg
`default_nettype wire

// file: src/cxab_burst_split.sv
`default_nettype none
module cxab_burst_split (
    // Burst start and length field
    input  wire logic [6:0] word_in_span,
    input  wire logic [6:0] len_field,
    // Split result in words
    output logic      [7:0] first_len,
    output logic      [7:0] rest_len
);
    logic [7:0] total;
    logic [7:0] room;

    // Zero length means a full span; cut at the 256-byte boundary
    always_comb begin
        total     = (len_field == 7'h00) ? cxab_pkg::SPAN_WORDS : {1'b0, len_field};
        room      = cxab_pkg::SPAN_WORDS - {1'b0, word_in_span};
        first_len = (total < room) ? total : room;
        rest_len  = total - first_len;
    end
endmodule : cxab_burst_split
`default_nettype wire

// file: testbench/cxab_bridge_checker.sv
`default_nettype none
module cxab_bridge_checker (
    // Clock and reset
    input wire logic        REF_CLK,
    input wire logic        RESETN,
    // Host access port
    input wire logic        HOST_SEL,
    input wire logic        HOST_WR,
    input wire logic        HOST_DAS,
    input wire logic        HOST_BUS8,
    input wire logic [15:0] HOST_ADDR,
    input wire logic [15:0] HOST_WDATA,
    input wire logic [15:0] HOST_RDATA,
    input wire logic        HOST_READY,
    // Internal memory port
    input wire logic        MEM_REQ,
    input wire logic [32:0] MEM_ADDR,
    input wire logic [1:0]  MEM_WE,
    input wire logic [15:0] MEM_WDATA,
    input wire logic [1:0]  MEM_WPAR,
    input wire logic [7:0]  MEM_BURST,
    input wire logic        MEM_ACK,
    input wire logic [15:0] MEM_RDATA,
    input wire logic [1:0]  MEM_RPAR
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    logic dir_busy;
    logic next_dir_busy;
    // Direct access outstanding until its ready pulse
    always_comb begin
        next_dir_busy = dir_busy;
        if (dir_busy && HOST_READY) next_dir_busy = 1'b0;
        else if (HOST_SEL && HOST_DAS) next_dir_busy = 1'b1;
    end
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) dir_busy <= 1'b0;
        else dir_busy <= next_dir_busy;
    end
    // Accesses taken by the host port
    sequence s_reg_take;
        HOST_SEL && !HOST_DAS && !dir_busy;
    endsequence
    sequence s_dir_take;
        HOST_SEL && HOST_DAS && !dir_busy;
    endsequence
    AST_REG_ANSWER: assert property (s_reg_take |=> HOST_READY)
        else $error("register access unanswered");
    AST_DIR_START: assert property (s_dir_take ##0 !MEM_REQ |-> ##2 MEM_REQ)
        else $error("direct access not started");
    AST_DIR_DONE: assert property (s_dir_take |-> ##[2:300] HOST_READY)
        else $error("direct access not done");
    AST_MEM_HOLD: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE)
        && $stable(MEM_BURST) && $stable(MEM_WDATA))
        else $error("request changed before ack");
    AST_ADDR_EVEN: assert property (MEM_REQ |-> !MEM_ADDR[0])
        else $error("address not word aligned");
    AST_BURST_RANGE: assert property (MEM_REQ && MEM_WE == 2'h0 |-> MEM_BURST inside {[8'h01:8'h80]})
        else $error("burst length out of range");
    AST_SPAN: assert property (MEM_REQ && MEM_WE == 2'h0
        |-> ({2'h0, MEM_ADDR[7:1]} + {1'b0, MEM_BURST}) <= 9'h080)
        else $error("burst crosses 256-byte span");
    AST_WRITE_ONE: assert property (MEM_REQ && MEM_WE != 2'h0 |-> MEM_BURST == 8'h01)
        else $error("write burst not one word");
    AST_RDATA_HOLD: assert property ($changed(HOST_RDATA) |-> HOST_READY)
        else $error("read data changed without ready");
endmodule : cxab_bridge_checker
`default_nettype wire

// file: testbench/cxab_mem_model.sv
`default_nettype none
module cxab_mem_model #(
    parameter int LAT = 8
) (
    // Clock, reset and pacing
    input wire logic         REF_CLK,
    input wire logic         RESETN,
    input wire logic         slow,
    // Request from the bridge
    input wire logic         MEM_REQ,
    input wire logic  [32:0] MEM_ADDR,
    input wire logic  [1:0]  MEM_WE,
    input wire logic  [15:0] MEM_WDATA,
    input wire logic  [1:0]  MEM_WPAR,
    input wire logic  [7:0]  MEM_BURST,
    // Answer to the bridge
    output logic             MEM_ACK,
    output logic      [15:0] MEM_RDATA,
    output logic      [1:0]  MEM_RPAR
);
    logic [3:0]  cnt;
    logic [15:0] rd, w_data;
    logic [1:0]  rp, w_we, w_par;
    logic [32:0] w_addr, b_addr0, b_addr1;
    logic [7:0]  b_len0, b_len1;
    // Off the ack cycle the lines show the inverse
    assign MEM_RDATA = MEM_ACK ? rd : ~rd;
    assign MEM_RPAR  = MEM_ACK ? rp : ~rp;
    // Answer after the latency and record the request
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            {cnt, MEM_ACK, rd, rp, w_data, w_we, w_par, w_addr} <= '0;
            {b_addr0, b_addr1, b_len0, b_len1} <= '0;
        end else begin
            MEM_ACK <= 1'b0;
            if (MEM_REQ && !MEM_ACK) begin
                if (int'(cnt) >= (slow ? LAT : 0)) begin
                    MEM_ACK <= 1'b1;
                    cnt <= 4'h0;
                    rd <= MEM_ADDR[16:1] ^ 16'hc3a5;
                    rp <= {^MEM_ADDR[16:9], ^MEM_ADDR[8:1]};
                    {b_addr1, b_addr0, b_len1, b_len0} <= {b_addr0, MEM_ADDR, b_len0, MEM_BURST};
                    if (MEM_WE != 2'h0) {w_addr, w_we, w_data, w_par} <= {MEM_ADDR, MEM_WE, MEM_WDATA, MEM_WPAR};
                end else cnt <= cnt + 4'h1;
            end
        end
    end
endmodule : cxab_mem_model
`default_nettype wire

// file: testbench/cxab_bridge_tb.sv
`default_nettype none
module cxab_bridge_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        REF_CLK, RESETN, HOST_SEL, HOST_WR, HOST_DAS, HOST_BUS8, HOST_READY, MEM_REQ, MEM_ACK, slow;
    logic [15:0] HOST_ADDR, HOST_WDATA, HOST_RDATA, MEM_WDATA, MEM_RDATA, rv;
    logic [32:0] MEM_ADDR, ea;
    logic [1:0]  MEM_WE, MEM_WPAR, MEM_RPAR;
    logic [7:0]  MEM_BURST;
    int          mismatches, comparisons;
    cxab_bridge cxab_bridge_inst (.REF_CLK(REF_CLK), .RESETN(RESETN), .HOST_SEL(HOST_SEL), .HOST_WR(HOST_WR),
        .HOST_DAS(HOST_DAS), .HOST_BUS8(HOST_BUS8), .HOST_ADDR(HOST_ADDR), .HOST_WDATA(HOST_WDATA),
        .HOST_RDATA(HOST_RDATA), .HOST_READY(HOST_READY), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_WE(MEM_WE),
        .MEM_WDATA(MEM_WDATA), .MEM_WPAR(MEM_WPAR), .MEM_BURST(MEM_BURST), .MEM_ACK(MEM_ACK),
        .MEM_RDATA(MEM_RDATA), .MEM_RPAR(MEM_RPAR));
    cxab_mem_model mem (.REF_CLK(REF_CLK), .RESETN(RESETN), .slow(slow), .MEM_REQ(MEM_REQ),
        .MEM_ADDR(MEM_ADDR), .MEM_WE(MEM_WE), .MEM_WDATA(MEM_WDATA), .MEM_WPAR(MEM_WPAR), .MEM_BURST(MEM_BURST),
        .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .MEM_RPAR(MEM_RPAR));
    // 20 MHz clock
    initial begin
        REF_CLK = 1'b0;
        forever #25 REF_CLK = ~REF_CLK;
    end
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One host strobe, then wait for its ready pulse
    task automatic acc(input logic wr, input logic das, input logic [15:0] a, input logic [15:0] d);
        int n;
        @(posedge REF_CLK);
        #1;
        {HOST_SEL, HOST_WR, HOST_DAS, HOST_ADDR, HOST_WDATA} = {1'b1, wr, das, a, d};
        @(posedge REF_CLK);
        #1;
        HOST_SEL = 1'b0;
        n = 0;
        while (HOST_READY !== 1'b1 && n < 50) begin
            @(posedge REF_CLK);
            #1;
            n++;
        end
        if (!das) chk(33'(n), 33'h0);
        chk(HOST_READY, 1'b1);
        rv = HOST_RDATA;
    endtask : acc
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask : wr
    task automatic rd(input logic [15:0] a);
        acc(1'b0, 1'b0, a, 16'h0000);
    endtask : rd
    // Poll the request bit until it clears
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            rd(cxab_pkg::OFS_CTRL);
            n++;
        end while (rv[8] !== 1'b0 && n < 50);
        chk(rv[8], 1'b0);
    endtask : wait_done
    function automatic logic [1:0] par(input logic [32:0] a);
        return {^a[16:9], ^a[8:1]};
    endfunction : par
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge REF_CLK);
        mismatches++;
        wrap_up();
    end
    // Main sequence
    initial begin
        logic [15:0] ofs [5];
        logic [15:0] rst [5];
        ofs = '{cxab_pkg::OFS_CTRL, cxab_pkg::OFS_DATA, cxab_pkg::OFS_AHI, cxab_pkg::OFS_ALO, 16'h000c};
        rst = '{16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        {RESETN, HOST_SEL, HOST_WR, HOST_DAS, HOST_BUS8, HOST_ADDR, HOST_WDATA, slow} = '0;
        repeat (8) @(posedge REF_CLK);
        #1;
        RESETN = 1'b1;
        // Reset values, unmapped place reads zero
        for (int i = 0; i < 5; i++) begin
            rd(ofs[i]);
            chk(rv, rst[i]);
        end
        // Reserved high bits read zero, low address is fully kept
        wr(cxab_pkg::OFS_AHI, 16'hffff);
        rd(cxab_pkg::OFS_AHI);
        chk(rv, 16'h1fff);
        wr(cxab_pkg::OFS_ALO, 16'hbeef);
        rd(cxab_pkg::OFS_ALO);
        chk(rv, 16'hbeef);
        // Indirect writes with every write-enable code
        wr(cxab_pkg::OFS_AHI, 16'h0123);
        wr(cxab_pkg::OFS_ALO, 16'habcd);
        wr(cxab_pkg::OFS_DATA, 16'h5a3c);
        for (int w = 1; w < 4; w++) begin
            wr(cxab_pkg::OFS_CTRL, {2'b10, w[1:0], 3'b101, 1'b1, 8'h01});
            wait_done();
            chk(mem.w_addr, {13'h0123, 16'habcd, 3'b101, 1'b0});
            chk(mem.w_we, w[1:0]);
            chk(mem.w_data, 16'h5a3c);
            chk(mem.w_par, 2'b10);
        end
        // Slow indirect read; a control write while pending is dropped
        slow = 1'b1;
        wr(cxab_pkg::OFS_CTRL, {7'h03, 1'b1, 8'h01});
        wr(cxab_pkg::OFS_CTRL, 16'h0000);
        rd(cxab_pkg::OFS_CTRL);
        chk(rv[8], 1'b1);
        wait_done();
        slow = 1'b0;
        ea = {13'h0123, 16'habcd, 3'b011, 1'b0};
        chk(mem.b_addr0, ea);
        rd(cxab_pkg::OFS_DATA);
        chk(rv, ea[16:1] ^ 16'hc3a5);
        rd(cxab_pkg::OFS_CTRL);
        chk(rv[15:14], par(ea));
        // Read burst crossing a 256-byte boundary, then length zero
        wr(cxab_pkg::OFS_ALO, 16'h000f);
        wr(cxab_pkg::OFS_CTRL, {7'h06, 1'b1, 8'h05});
        wait_done();
        ea = {13'h0123, 16'h000f, 3'b110, 1'b0};
        chk(mem.b_addr1, ea);
        chk(mem.b_len1, 8'h02);
        chk(mem.b_addr0, (ea | 33'h0ff) + 33'h1);
        chk(mem.b_len0, 8'h03);
        wr(cxab_pkg::OFS_ALO, 16'h0000);
        wr(cxab_pkg::OFS_CTRL, {7'h00, 1'b1, 8'h00});
        wait_done();
        chk(mem.b_len0, 8'h80);
        // Direct word write and read through the page base
        wr(cxab_pkg::OFS_CTRL, {2'b01, 2'b11, 3'b000, 1'b0, 8'h01});
        wr(cxab_pkg::OFS_AHI, 16'h0002);
        wr(cxab_pkg::OFS_ALO, 16'hf123);
        wr(cxab_pkg::OFS_DATA, 16'h1111);
        acc(1'b1, 1'b1, 16'h0246, 16'h1357);
        ea = {13'h0002, 4'hf, 15'h0123, 1'b0};
        chk(mem.w_addr, ea);
        chk(mem.w_we, 2'b11);
        chk(mem.w_par, 2'b01);
        chk(mem.w_data, 16'h1357);
        rd(cxab_pkg::OFS_DATA);
        chk(rv, 16'h1111);
        acc(1'b0, 1'b1, 16'h0246, 16'h0000);
        chk(rv, ea[16:1] ^ 16'hc3a5);
        rd(cxab_pkg::OFS_CTRL);
        chk(rv[15:14], par(ea));
        // Byte-wide direct write picks the lane from the address
        HOST_BUS8 = 1'b1;
        acc(1'b1, 1'b1, 16'h4321, 16'h00a5);
        ea = {13'h0002, 5'h1e, 14'h2190, 1'b0};
        chk(mem.w_addr, ea);
        chk(mem.w_we, 2'b10);
        chk(mem.w_data, 16'ha5a5);
        // Byte-wide read and register byte lanes
        acc(1'b0, 1'b1, 16'h4321, 16'h0000);
        chk(rv, {8'h00, ea[16:9] ^ 8'hc3});
        wr(16'h0009, 16'h0077);
        rd(16'h0009);
        chk(rv, 16'h0017);
        wrap_up();
    end
endmodule : cxab_bridge_tb
bind cxab_bridge cxab_bridge_checker cxab_bridge_checker_inst (.REF_CLK(REF_CLK), .RESETN(RESETN),
    .HOST_SEL(HOST_SEL), .HOST_WR(HOST_WR), .HOST_DAS(HOST_DAS), .HOST_BUS8(HOST_BUS8), .HOST_ADDR(HOST_ADDR),
    .HOST_WDATA(HOST_WDATA), .HOST_RDATA(HOST_RDATA), .HOST_READY(HOST_READY), .MEM_REQ(MEM_REQ),
    .MEM_ADDR(MEM_ADDR), .MEM_WE(MEM_WE), .MEM_WDATA(MEM_WDATA), .MEM_WPAR(MEM_WPAR), .MEM_BURST(MEM_BURST),
    .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .MEM_RPAR(MEM_RPAR));
`default_nettype wire
